// ---- rtl/acr_defines.svh ----
// register offsets, field positions, reset values and code tables of the
// converter configuration bank; definitions only
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

// register offsets on the command port
`define ACR_OFS_CLOCK 6'h03
`define ACR_OFS_GAIN 6'h04
`define ACR_OFS_CFG 6'h06
`define ACR_OFS_CH0CFG 6'h09
`define ACR_OFS_OFSU 6'h0a
`define ACR_OFS_OFSL 6'h0b
`define ACR_OFS_GAINU 6'h0c

// reset values
`define ACR_RST_CLOCK 16'h030e
`define ACR_RST_GAIN 16'h0000
`define ACR_RST_CFG 16'h0600
`define ACR_RST_CH0CFG 16'h0000
`define ACR_RST_OFSU 16'h0000
`define ACR_RST_OFSL 16'h0000
`define ACR_RST_GAINU 16'h8000

// writable bits; the rest read as zero
`define ACR_MSK_CLOCK 16'h03ff
`define ACR_MSK_GAIN 16'h0077
`define ACR_MSK_CFG 16'h7f00
`define ACR_MSK_CH0CFG 16'hffc3
`define ACR_MSK_OFSL 16'hff00

// clocking and sampling fields
`define ACR_SECOND_ON 9
`define ACR_FIRST_ON 8
`define ACR_DIV_HI 7
`define ACR_DIV_LO 6
`define ACR_TURBO 5
`define ACR_OSR_HI 4
`define ACR_OSR_LO 2
`define ACR_PWR_HI 1
`define ACR_PWR_LO 0

// gain fields
`define ACR_G1_HI 6
`define ACR_G1_LO 4
`define ACR_G0_HI 2
`define ACR_G0_LO 0

// chop and digital output fields
`define ACR_DOUT_EN 14
`define ACR_DOUT_LVL 13
`define ACR_DLY_HI 12
`define ACR_DLY_LO 9
`define ACR_CHOP_EN 8

// first channel fields
`define ACR_PH_HI 15
`define ACR_PH_LO 6
`define ACR_MUX_HI 1
`define ACR_MUX_LO 0
`define ACR_OFSL_HI 15
`define ACR_OFSL_LO 8

// code tables
`define ACR_OSR_TURBO 15'h0040
`define ACR_OSR_BASE 15'h0080
`define ACR_DLY_MAX_CODE 4'hf
`define ACR_DLY_MAX 17'h10000
`define ACR_DLY_BASE 17'h00002
`define ACR_DIV12_TERM 4'hb
`define ACR_SAT_POS 24'h7fffff
`define ACR_SAT_NEG 24'h800000

`endif

// ---- rtl/acr_pkg.sv ----
// types shared by the configuration bank and its modulator clock divider
package acr_pkg;

   typedef enum logic [1:0] {
      ACR_PWR_RSV0 = 2'h0,
      ACR_PWR_LOW = 2'h1,
      ACR_PWR_HIRES = 2'h2,
      ACR_PWR_RSV3 = 2'h3
   } acr_pwr_t;

   typedef enum logic [1:0] {
      ACR_IN_PINS = 2'h0,
      ACR_IN_SHORT = 2'h1,
      ACR_IN_DC_DIAG = 2'h2,
      ACR_IN_AC_DIAG = 2'h3
   } acr_input_t;

   // one register command as handed over by the serial front end
   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [15:0] wdata;
   } acr_reg_req_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } acr_reg_rsp_t;

endpackage : acr_pkg

// ---- rtl/acr_mod_clk_div.sv ----
// modulator clock enable: one-cycle pulse every 2, 4, 8 or 12 input clocks
// assumes the selector is a register output in the same clock domain
`timescale 1ns/10ps
`default_nettype none
`include "acr_defines.svh"

module acr_mod_clk_div import acr_pkg::*; #(
   parameter int CNT_W = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] div_sel,
   output logic tick
);

   generate
      if (CNT_W < 4) begin : g_chk
         $error("acr_mod_clk_div: CNT_W must hold a count of 11");
      end
   endgenerate

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] term;
   logic at_term;

   // 00 -> 2, 01 -> 4, 10 -> 8, 11 -> 12
   assign term = (div_sel == 2'h3) ? CNT_W'(`ACR_DIV12_TERM) :
                 CNT_W'((5'h02 << div_sel) - 5'h01);
   // a shrinking ratio must not leave the count stranded above the end
   assign at_term = (cnt_r >= term);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         tick <= 1'b0;
      end else begin
         cnt_r <= at_term ? '0 : cnt_r + CNT_W'(1);
         tick <= at_term;
      end
   end

endmodule : acr_mod_clk_div
`default_nettype wire

// ---- rtl/acr_config_bank.sv ----
// configuration register bank of a two-channel delta-sigma converter
// assumes a serial front end that hands over decoded single-cycle commands
`timescale 1ns/10ps
`default_nettype none
`include "acr_defines.svh"

module acr_config_bank import acr_pkg::*; #(
   parameter int DATA_W = 24,
   parameter int DIV_CNT_W = 4
) (
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // register commands
   input wire acr_reg_req_t REG_REQ,
   output acr_reg_rsp_t REG_RSP,
   // converter control
   output logic CH0_ENABLE,
   output logic CH1_ENABLE,
   output logic MOD_CLK_EN,
   output logic [14:0] OVERSAMPLING_RATIO,
   output acr_pwr_t POWER_MODE,
   output logic [7:0] FIRST_CHANNEL_GAIN,
   output logic [7:0] SECOND_CHANNEL_GAIN,
   output logic CHOP_ENABLE,
   output logic [16:0] CHOP_SETTLING_DELAY,
   output logic signed [9:0] FIRST_CHANNEL_PHASE_DELAY,
   output acr_input_t FIRST_CHANNEL_INPUT_SELECT,
   output logic [23:0] FIRST_OFFSET,
   output logic [23:0] FIRST_GAIN_WORD,
   // spare input pin as digital output
   output logic SPARE_POSITIVE_INPUT_PIN_O,
   output logic SPARE_POSITIVE_INPUT_PIN_OE,
   // first channel conversion results
   input wire logic CONV0_VALID,
   input wire logic [23:0] CONV0_DATA,
   output logic CORR0_VALID,
   output logic [23:0] CORR0_DATA
);

   generate
      if (DATA_W != 24) begin : g_chk
         $error("acr_config_bank: DATA_W must be 24");
      end
   endgenerate

   // stored register words, writable bits only
   logic [15:0] clock_r;
   logic [15:0] clock_nxt;
   logic [15:0] gain_r;
   logic [15:0] cfg_r;
   logic [15:0] ch0cfg_r;
   logic [15:0] ofsu_r;
   logic [15:0] ofsl_r;
   logic [15:0] gainu_r;
   logic [15:0] rd_data;

   // write decode
   wire wr_clock = REG_REQ.wr && (REG_REQ.addr == `ACR_OFS_CLOCK);
   wire wr_gain = REG_REQ.wr && (REG_REQ.addr == `ACR_OFS_GAIN);
   wire wr_cfg = REG_REQ.wr && (REG_REQ.addr == `ACR_OFS_CFG);
   wire wr_ch0cfg = REG_REQ.wr && (REG_REQ.addr == `ACR_OFS_CH0CFG);
   wire wr_ofsu = REG_REQ.wr && (REG_REQ.addr == `ACR_OFS_OFSU);
   wire wr_ofsl = REG_REQ.wr && (REG_REQ.addr == `ACR_OFS_OFSL);
   wire wr_gainu = REG_REQ.wr && (REG_REQ.addr == `ACR_OFS_GAINU);

   // a forbidden power code would leave the modulator unbiased, so keep the old one
   wire [1:0] pwr_wr = REG_REQ.wdata[`ACR_PWR_HI:`ACR_PWR_LO];
   wire pwr_legal = (pwr_wr == ACR_PWR_LOW) || (pwr_wr == ACR_PWR_HIRES);
   wire [1:0] pwr_keep = pwr_legal ? pwr_wr : clock_r[`ACR_PWR_HI:`ACR_PWR_LO];

   assign clock_nxt = {REG_REQ.wdata[15:2] & 14'(`ACR_MSK_CLOCK >> 2), pwr_keep};

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         clock_r <= `ACR_RST_CLOCK;
         gain_r <= `ACR_RST_GAIN;
         cfg_r <= `ACR_RST_CFG;
         ch0cfg_r <= `ACR_RST_CH0CFG;
         ofsu_r <= `ACR_RST_OFSU;
         ofsl_r <= `ACR_RST_OFSL;
         gainu_r <= `ACR_RST_GAINU;
      end else begin
         if (wr_clock) clock_r <= clock_nxt;
         if (wr_gain) gain_r <= REG_REQ.wdata & `ACR_MSK_GAIN;
         if (wr_cfg) cfg_r <= REG_REQ.wdata & `ACR_MSK_CFG;
         if (wr_ch0cfg) ch0cfg_r <= REG_REQ.wdata & `ACR_MSK_CH0CFG;
         if (wr_ofsu) ofsu_r <= REG_REQ.wdata;
         if (wr_ofsl) ofsl_r <= REG_REQ.wdata & `ACR_MSK_OFSL;
         if (wr_gainu) gainu_r <= REG_REQ.wdata;
      end
   end

   // read decode; unmapped offsets read zero
   always_comb begin
      if (REG_REQ.addr == `ACR_OFS_CLOCK) begin
         rd_data = clock_r;
      end else if (REG_REQ.addr == `ACR_OFS_GAIN) begin
         rd_data = gain_r;
      end else if (REG_REQ.addr == `ACR_OFS_CFG) begin
         rd_data = cfg_r;
      end else if (REG_REQ.addr == `ACR_OFS_CH0CFG) begin
         rd_data = ch0cfg_r;
      end else if (REG_REQ.addr == `ACR_OFS_OFSU) begin
         rd_data = ofsu_r;
      end else if (REG_REQ.addr == `ACR_OFS_OFSL) begin
         rd_data = ofsl_r;
      end else if (REG_REQ.addr == `ACR_OFS_GAINU) begin
         rd_data = gainu_r;
      end else begin
         rd_data = 16'h0000;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         REG_RSP <= '0;
      end else begin
         REG_RSP.valid <= REG_REQ.rd;
         REG_RSP.data <= REG_REQ.rd ? rd_data : 16'h0000;
      end
   end

   // field decode
   wire [2:0] osr_code = clock_r[`ACR_OSR_HI:`ACR_OSR_LO];
   wire [14:0] osr_nxt = clock_r[`ACR_TURBO] ? `ACR_OSR_TURBO :
                         (`ACR_OSR_BASE << osr_code);
   wire [7:0] g1_nxt = 8'h01 << gain_r[`ACR_G1_HI:`ACR_G1_LO];
   wire [7:0] g0_nxt = 8'h01 << gain_r[`ACR_G0_HI:`ACR_G0_LO];
   wire [3:0] dly_code = cfg_r[`ACR_DLY_HI:`ACR_DLY_LO];
   // code 1110 is not listed; it continues the doubling to 32768
   wire [16:0] dly_nxt = (dly_code == `ACR_DLY_MAX_CODE) ? `ACR_DLY_MAX :
                         (`ACR_DLY_BASE << dly_code);
   wire [23:0] ofs_full = {ofsu_r, ofsl_r[`ACR_OFSL_HI:`ACR_OFSL_LO]};

   // offset correction, saturated so a large offset cannot wrap the sign
   wire [24:0] sum = {CONV0_DATA[23], CONV0_DATA} + {ofs_full[23], ofs_full};
   wire sum_ovf = sum[24] != sum[23];
   wire [23:0] corr_nxt = sum_ovf ? (sum[24] ? `ACR_SAT_NEG : `ACR_SAT_POS) : sum[23:0];

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         CH0_ENABLE <= 1'b0;
         CH1_ENABLE <= 1'b0;
         OVERSAMPLING_RATIO <= '0;
         POWER_MODE <= ACR_PWR_RSV0;
         FIRST_CHANNEL_GAIN <= '0;
         SECOND_CHANNEL_GAIN <= '0;
         CHOP_ENABLE <= 1'b0;
         CHOP_SETTLING_DELAY <= '0;
         FIRST_CHANNEL_PHASE_DELAY <= '0;
         FIRST_CHANNEL_INPUT_SELECT <= ACR_IN_PINS;
         FIRST_OFFSET <= '0;
         FIRST_GAIN_WORD <= '0;
         SPARE_POSITIVE_INPUT_PIN_O <= 1'b0;
         SPARE_POSITIVE_INPUT_PIN_OE <= 1'b0;
      end else begin
         CH1_ENABLE <= clock_r[`ACR_SECOND_ON];
         CH0_ENABLE <= clock_r[`ACR_FIRST_ON];
         OVERSAMPLING_RATIO <= osr_nxt;
         POWER_MODE <= acr_pwr_t'(clock_r[`ACR_PWR_HI:`ACR_PWR_LO]);
         SECOND_CHANNEL_GAIN <= g1_nxt;
         FIRST_CHANNEL_GAIN <= g0_nxt;
         CHOP_ENABLE <= cfg_r[`ACR_CHOP_EN];
         CHOP_SETTLING_DELAY <= dly_nxt;
         FIRST_CHANNEL_PHASE_DELAY <= ch0cfg_r[`ACR_PH_HI:`ACR_PH_LO];
         FIRST_CHANNEL_INPUT_SELECT <= acr_input_t'(ch0cfg_r[`ACR_MUX_HI:`ACR_MUX_LO]);
         FIRST_OFFSET <= ofs_full;
         // low gain byte lives in a register outside this bank
         FIRST_GAIN_WORD <= {gainu_r, 8'h00};
         SPARE_POSITIVE_INPUT_PIN_OE <= cfg_r[`ACR_DOUT_EN];
         // level held low while analog so enabling never glitches high first
         SPARE_POSITIVE_INPUT_PIN_O <= cfg_r[`ACR_DOUT_EN] & cfg_r[`ACR_DOUT_LVL];
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         CORR0_VALID <= 1'b0;
         CORR0_DATA <= '0;
      end else begin
         CORR0_VALID <= CONV0_VALID;
         if (CONV0_VALID) CORR0_DATA <= corr_nxt;
      end
   end

   acr_mod_clk_div #(
      .CNT_W(DIV_CNT_W)
   ) u_div (
      .clk(CLK),
      .rst(SYS_RST),
      .div_sel(clock_r[`ACR_DIV_HI:`ACR_DIV_LO]),
      .tick(MOD_CLK_EN)
   );

endmodule : acr_config_bank
`default_nettype wire

// ---- tb/acr_host_model.sv ----
// host model: issues single-cycle register commands to the bank
// assumes a read answer registered on the taking edge
`timescale 1ns/10ps
`default_nettype none
module acr_host_model import acr_pkg::*; (
   // bank clock
   input wire logic clk,
   // command port
   output var acr_reg_req_t req,
   input wire acr_reg_rsp_t rsp
);
   initial req = '0;
   task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d, output logic [16:0] q);
      @(posedge clk);
      #1 req = {w, !w, a, d};
      @(posedge clk);
      #1 q = rsp;
      // idle lines show the inverse, never a stale copy
      req = {2'b00, ~a, ~d};
      if (w) begin
         @(posedge clk);
         #1;
      end
   endtask : xfer
endmodule : acr_host_model
`default_nettype wire

// ---- tb/acr_config_bank_sva.sv ----
// port assertions of the configuration bank
// bound into the bank; one clock domain
`timescale 1ns/10ps
`default_nettype none
`include "acr_defines.svh"
module acr_config_bank_sva import acr_pkg::*; (
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // register commands
   input wire acr_reg_req_t REG_REQ,
   input wire acr_reg_rsp_t REG_RSP,
   // observed outputs and the conversion valid input
   input wire logic CH0_ENABLE,
   input wire logic MOD_CLK_EN,
   input wire logic [14:0] OVERSAMPLING_RATIO,
   input wire logic [7:0] FIRST_CHANNEL_GAIN,
   input wire logic CHOP_ENABLE,
   input wire logic SPARE_POSITIVE_INPUT_PIN_O,
   input wire logic SPARE_POSITIVE_INPUT_PIN_OE,
   input wire logic CONV0_VALID,
   input wire logic CORR0_VALID
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   wire logic w03 = REG_REQ.wr && REG_REQ.addr == `ACR_OFS_CLOCK;
   wire logic w06 = REG_REQ.wr && REG_REQ.addr == `ACR_OFS_CFG;
   chk_low_byte_zero: assert property (REG_REQ.rd && REG_REQ.addr == `ACR_OFS_OFSL
      |=> REG_RSP.valid && REG_RSP.data[7:0] == 8'h00) else $error("offset low byte not answered as zero");
   chk_valid_cause: assert property (REG_RSP.valid |-> $past(REG_REQ.rd)) else $error("answer without read");
   chk_turbo_ratio: assert property (w03 && REG_REQ.wdata[5] ##1 !w03
      |=> OVERSAMPLING_RATIO == 15'h0040) else $error("turbo ratio wrong");
   chk_ratio_code: assert property (w03 && !REG_REQ.wdata[5] ##1 !w03
      |=> OVERSAMPLING_RATIO == 15'h0080 << $past(REG_REQ.wdata[4:2], 2)) else $error("ratio wrong");
   chk_chan_enable: assert property (w03 ##1 !w03
      |=> CH0_ENABLE == $past(REG_REQ.wdata[8], 2)) else $error("channel enable wrong");
   chk_chop_follow: assert property (w06 ##1 !w06
      |=> CHOP_ENABLE == $past(REG_REQ.wdata[8], 2)) else $error("chop enable wrong");
   chk_pin_enable: assert property (w06 ##1 !w06
      |=> SPARE_POSITIVE_INPUT_PIN_OE == $past(REG_REQ.wdata[14], 2)) else $error("pin enable wrong");
   chk_pin_quiet: assert property (!SPARE_POSITIVE_INPUT_PIN_OE
      |-> !SPARE_POSITIVE_INPUT_PIN_O) else $error("pin level while disabled");
   chk_gain_onehot: assert property (!$past(SYS_RST) |-> $onehot(FIRST_CHANNEL_GAIN)) else $error("gain not power of two");
   chk_tick_apart: assert property (MOD_CLK_EN |=> !MOD_CLK_EN) else $error("ticks adjacent");
   chk_corr_follow: assert property (CONV0_VALID |=> CORR0_VALID) else $error("result not answered");
endmodule : acr_config_bank_sva
bind acr_config_bank acr_config_bank_sva i_sva (.CLK(CLK), .SYS_RST(SYS_RST), .REG_REQ(REG_REQ), .REG_RSP(REG_RSP),
   .CH0_ENABLE(CH0_ENABLE), .MOD_CLK_EN(MOD_CLK_EN), .OVERSAMPLING_RATIO(OVERSAMPLING_RATIO),
   .FIRST_CHANNEL_GAIN(FIRST_CHANNEL_GAIN), .CHOP_ENABLE(CHOP_ENABLE), .SPARE_POSITIVE_INPUT_PIN_O(SPARE_POSITIVE_INPUT_PIN_O),
   .SPARE_POSITIVE_INPUT_PIN_OE(SPARE_POSITIVE_INPUT_PIN_OE), .CONV0_VALID(CONV0_VALID), .CORR0_VALID(CORR0_VALID));
`default_nettype wire

// ---- tb/acr_config_bank_test.sv ----
// self-checking bench of the configuration bank
// commands go through the host model; single clock
`timescale 1ns/10ps
`default_nettype none
`include "acr_defines.svh"
module acr_config_bank_test import acr_pkg::*;;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cv = 1'b0;
   logic [23:0] cd = 24'h000000;
   acr_reg_req_t req;
   acr_reg_rsp_t rsp;
   logic e0, e1, tick, chop, po, poe, corr_v;
   logic [14:0] osr;
   acr_pwr_t pwr;
   logic [7:0] g0, g1;
   logic [16:0] dly;
   logic signed [9:0] ph;
   acr_input_t mux;
   logic [23:0] ofs, gw, corr;
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [5:0] ot [8] = '{`ACR_OFS_CLOCK, `ACR_OFS_GAIN, `ACR_OFS_CFG, `ACR_OFS_CH0CFG,
      `ACR_OFS_OFSU, `ACR_OFS_OFSL, `ACR_OFS_GAINU, 6'h3f};
   logic [15:0] rt [8] = '{16'h030e, 16'h0000, 16'h0600, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
   logic [15:0] ft [8] = '{16'h03fe, 16'h0077, 16'h7f00, 16'hffc3, 16'hffff, 16'hff00, 16'hffff, 16'h0000};
   always #2.5 clk = ~clk;
   acr_host_model host (.clk(clk), .req(req), .rsp(rsp));
   acr_config_bank i_acr_config_bank (.CLK(clk), .SYS_RST(sys_rst), .REG_REQ(req), .REG_RSP(rsp),
      .CH0_ENABLE(e0), .CH1_ENABLE(e1), .MOD_CLK_EN(tick), .OVERSAMPLING_RATIO(osr), .POWER_MODE(pwr),
      .FIRST_CHANNEL_GAIN(g0), .SECOND_CHANNEL_GAIN(g1), .CHOP_ENABLE(chop), .CHOP_SETTLING_DELAY(dly),
      .FIRST_CHANNEL_PHASE_DELAY(ph), .FIRST_CHANNEL_INPUT_SELECT(mux), .FIRST_OFFSET(ofs), .FIRST_GAIN_WORD(gw),
      .SPARE_POSITIVE_INPUT_PIN_O(po), .SPARE_POSITIVE_INPUT_PIN_OE(poe), .CONV0_VALID(cv), .CONV0_DATA(cd),
      .CORR0_VALID(corr_v), .CORR0_DATA(corr));
   task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [16:0] q;
      host.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      logic [16:0] q;
      host.xfer(1'b0, a, 16'h0000, q);
      chk("read", {7'h00, q}, {8'h01, e});
   endtask : rd
   // last of three periods, so a code change has settled
   task automatic tick_period(input int e);
      int n;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         do begin
            @(posedge clk);
            #1 n++;
         end while (tick !== 1'b1 && n < 40);
      end
      chk("tick period", 24'(n), 24'(e));
   endtask : tick_period
   task automatic conv(input logic [23:0] d, input logic [23:0] e);
      @(posedge clk);
      #1 cv = 1'b1;
      cd = d;
      @(posedge clk);
      #1 cv = 1'b0;
      cd = ~d;
      chk("corr valid", {23'h0, corr_v}, 24'h000001);
      chk("corrected", corr, e);
   endtask : conv
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      #1 sys_rst = 1'b0;
      foreach (ot[i]) rd(ot[i], rt[i]);
      chk("ratio", osr, 24'h000400);
      chk("power", pwr, 24'h000002);
      chk("enables", {e1, e0}, 24'h000003);
      chk("gain", g0, 24'h000001);
      chk("delay", dly, 24'h000010);
      chk("gain word", gw, 24'h800000);
      chk("pin oe", poe, 24'h000000);
      $display("test reset done");
      // all ones: reserved bits dropped, illegal power code refused
      foreach (ot[i]) wr(ot[i], 16'hffff);
      foreach (ot[i]) rd(ot[i], ft[i]);
      chk("turbo", osr, 24'h000040);
      chk("power kept", pwr, 24'h000002);
      chk("gain1", g1, 24'h000080);
      chk("delay max", dly, 24'h010000);
      chk("pin", {poe, po}, 24'h000003);
      chk("phase", {14'h0, ph}, 24'h0003ff);
      chk("offset", ofs, 24'hffffff);
      chk("gain word", gw, 24'hffff00);
      $display("test all ones done");
      for (int c = 0; c < 8; c++) begin
         wr(`ACR_OFS_CLOCK, {6'h00, c[1:0], c[1:0], 1'b0, c[2:0], 2'b01});
         wr(`ACR_OFS_GAIN, {9'h000, c[2:0], 1'b0, c[2:0]});
         wr(`ACR_OFS_CH0CFG, {10'(-c), 4'hf, c[1:0]});
         chk("ratio", osr, 24'h000080 << c);
         chk("power low", pwr, 24'h000001);
         chk("enables", {e1, e0}, 24'(c[1:0]));
         chk("gains", {g1, g0}, {2{8'h01 << c}});
         chk("phase", {14'h0, ph}, {14'h0, 10'(-c)});
         chk("input", mux, 24'(c[1:0]));
         if (c < 4) tick_period(c == 3 ? 12 : 2 << c);
      end
      $display("test code tables done");
      // code 1110 continues the doubling to 32768
      for (int c = 0; c < 16; c++) begin
         wr(`ACR_OFS_CFG, {1'b0, c[1:0], c[3:0], c[0], 8'h00});
         chk("delay", dly, c == 15 ? 24'h010000 : 24'h000002 << c);
         chk("pin", {poe, po}, {c[1], c[1] & c[0]});
         chk("chop", chop, 24'(c[0]));
      end
      $display("test chop and pin done");
      wr(`ACR_OFS_OFSU, 16'h0000);
      wr(`ACR_OFS_OFSL, 16'h0100);
      chk("offset", ofs, 24'h000001);
      conv(24'h000010, 24'h000011);
      wr(`ACR_OFS_OFSU, 16'h7fff);
      wr(`ACR_OFS_OFSL, 16'hff00);
      conv(24'h000001, 24'h7fffff);
      wr(`ACR_OFS_OFSU, 16'h8000);
      wr(`ACR_OFS_OFSL, 16'h0000);
      conv(24'hffffff, 24'h800000);
      $display("test correction done");
      // mid-run reset: the offset and clock words return to their reset values and four outputs to the values decoded from the reset words
      @(posedge clk);
      #1 sys_rst = 1'b1;
      repeat (4) @(posedge clk);
      #1 sys_rst = 1'b0;
      rd(`ACR_OFS_OFSU, 16'h0000);
      rd(`ACR_OFS_CLOCK, 16'h030e);
      chk("offset", ofs, 24'h000000);
      chk("power", pwr, 24'h000002);
      chk("pin oe", poe, 24'h000000);
      chk("gain word", gw, 24'h800000);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule : acr_config_bank_test
`default_nettype wire
